//--- hdl/drive_terminal_io.v
/*
 * terminal i/o logic of a motor drive: input filtering, three-wire run
 * control, start-up protection, virtual inputs and output function
 * selection, with a classic wishbone register slave.
 * assumes raw terminal levels come from pins (synchronised here) and the
 * drive status flags come from logic on sys_clk.
 */
// Decided for this implementation: the address map and the Wishbone interface to the registers.
// Contract
// [RULE1] mode one: forward button starts forward run
// [RULE2] mode one: reverse button switches to reverse
// [RULE3] opening stop-enable stops; buttons need it closed
// [RULE4] latest valid button action sets run state
// [RULE5] mode two: run button starts, switch sets direction
// [RULE6] mode two: run honoured only while enable closed
// [RULE7] filter four inputs and pulse input, 0..100ms; here three contacts and the pulse input, four in all
// [RULE8] accept level after stable for filter time
// [RULE9] no protection: active terminal starts at power-on
// [RULE10] protection: need inactive then active again
// [RULE11] on/ready time 0..30s, default 1s
// [RULE12] virtual inputs take bit of selected parameter
// [RULE13] hex digit picks bit zero to fifteen
// [RULE14] status word: one bit per output
// [RULE15] codes 0,1,2: none, ready, forward
// [RULE16] codes 3,4,5: fault indications
// [RULE17] codes 6,7,8: swing, torque limit, reverse
// [RULE18] codes 9..12: limits and first detect range
// [RULE19] codes 13..16: second range, set, desired freqs
// [RULE20] codes 17..20: zero speed, zero current, overcurrent
// [RULE21] codes 21..27: counter, sequencer, pre-warnings
// [RULE22] relay one defaults to code 3, others 0
`timescale 1ns/1ps
`include "drive_terminal_io_map.vh"

module drive_terminal_io (
   input  wire        sys_clk,
   input  wire        sys_rst,
   input  wire        clkEn,
   // wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [31:0] wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // raw terminal pins: 0 stop_enable, 1 fwd/run, 2 rev/dir, 3 pulse
   input  wire [3:0]  terminalIn,
   // internal drive status flags, one per function code 0..31
   input  wire [31:0] driveFlags,
   // parameter value words that virtual inputs may select
   input  wire [15:0] paramBankA,
   input  wire [15:0] paramBankB,
   input  wire [15:0] paramBankC,
   // results
   output reg         runCmd,
   output reg         runReverse,
   output reg         terminalsReady,
   output reg  [3:0]  virtualInputs,
   output reg  [9:0]  outputPins
);

   // number of function registers (ten outputs)
   localparam NOUT = 10;

   // run-state codes, one-hot
   localparam ST_STOP = 3'b001;
   localparam ST_FWD  = 3'b010;
   localparam ST_REV  = 3'b100;

   // picks one bit of a word by a hex digit
   function pickBit;
      input [15:0] word;
      input [3:0]  digit;
      begin
         pickBit = word[digit]; // [RULE13]
      end
   endfunction

   // maps a virtual-input source code onto a parameter word
   function [15:0] srcWord;
      input [15:0] src;
      begin
         case (src)
            `RST_VIN_SRC_A: srcWord = paramBankA;
            `RST_VIN_SRC_B: srcWord = paramBankB;
            `RST_VIN_SRC_C: srcWord = paramBankC;
            default:        srcWord = 16'h0000;
         endcase
      end
   endfunction

   // software registers
   // all settings return to their defaults together with the bus
   reg [15:0] filterMs_r;            // input filter time, ms
   reg        protect_r;             // start-up terminal protection
   reg [15:0] readyMs_r;             // on/ready time, ms
   reg [15:0] vinSrc_r [0:3];        // virtual input source codes
   reg [15:0] vinDigits_r;           // bit-select digits
   reg [1:0]  wireMode_r;            // run control mode
   reg [5:0]  outFunc_r [0:NOUT-1];  // function code of each output

   // synchroniser stages
   reg [3:0]  syncA_r;
   reg [3:0]  syncB_r;

   // filter state
   reg [3:0]  accepted_r;            // filtered levels
   reg [21:0] stableCnt_r [0:3];     // stable-level cycle counters
   reg [15:0] msDiv_r;               // millisecond prescaler
   reg        msTick_r;

   // ready timer and protection
   reg [15:0] readyCnt_r;
   reg        armed_r;               // protection released
   reg [2:0]  runState_r;
   reg [2:0]  runState_nxt;
   reg [3:0]  accPrev_r;

   integer i;

   // filter target in cycles; zero means pass-through. the longest
   // setting, 100 ms, is 2.5 million cycles and fits the 22-bit counter,
   // so only the low bits of the product are kept
   wire [31:0] filterProd = filterMs_r * `CYC_PER_MS;
   wire [21:0] filterCyc  = filterProd[21:0];

   // two-flop synchroniser on the pin inputs; only the second stage is
   // read, so a metastable first stage never reaches the filter
   // contacts bounce for milliseconds, so the extra two cycles are free
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         syncA_r <= 4'h0;
         syncB_r <= 4'h0;
      end else if (clkEn) begin
         syncA_r <= terminalIn;
         syncB_r <= syncA_r;
      end
   end

   // millisecond tick for the ready timer
   // free-running from reset, as the ready counter is, so the first ready count is a full 1 ms
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         msDiv_r  <= 16'h0000;
         msTick_r <= 1'b0;
      end else if (clkEn) begin
         msTick_r <= (msDiv_r == `CYC_PER_MS - 1);
         if (msDiv_r == `CYC_PER_MS - 1)
            msDiv_r <= 16'h0000;
         else
            msDiv_r <= msDiv_r + 16'h0001;
      end
   end

   // debounce: a new level counts up until stable for the full time
   // any sample back at the accepted level restarts the count,
   // so a chattering contact never gets through
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         accepted_r <= 4'h0;
         for (i = 0; i < 4; i = i + 1)
            stableCnt_r[i] <= 22'h000000;
      end else if (clkEn) begin
         for (i = 0; i < 4; i = i + 1) begin
            if (syncB_r[i] == accepted_r[i]) begin
               stableCnt_r[i] <= 22'h000000;
            end else if (filterCyc == 22'h000000) begin
               accepted_r[i] <= syncB_r[i]; // [RULE8]
            end else if (stableCnt_r[i] + 22'h000001 >= filterCyc) begin
               accepted_r[i]  <= syncB_r[i]; // [RULE7] [RULE8]
               stableCnt_r[i] <= 22'h000000;
            end else begin
               stableCnt_r[i] <= stableCnt_r[i] + 22'h000001;
            end
         end
      end
   end

   // on/ready timer: terminals are honoured only once it expires
   // once ready, the flag holds until reset: a later, longer setting
   // does not take the terminals away again
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         readyCnt_r     <= 16'h0000;
         terminalsReady <= 1'b0;
      end else if (clkEn) begin
         if (readyCnt_r >= readyMs_r) begin
            terminalsReady <= 1'b1; // [RULE11]
         end else if (msTick_r) begin
            readyCnt_r <= readyCnt_r + 16'h0001;
         end
      end
   end

   // terminal aliases after filtering
   wire stopEn  = accepted_r[0];
   wire runBtn  = accepted_r[1];
   wire revBtn  = accepted_r[2];
   wire fwdEdge = accepted_r[1] & ~accPrev_r[1];
   wire revEdge = accepted_r[2] & ~accPrev_r[2];
   // run terminal active in the current mode
   wire runLevel = runBtn | (wireMode_r == `MODE_THREE_ONE && revBtn);

   // run-state decision; a later button event replaces the earlier one
   // in mode one a reverse edge beats a forward edge of the same cycle;
   // two presses closer than one clock cannot be ordered anyway
   always @* begin
      runState_nxt = runState_r;
      if (!terminalsReady || !stopEn) begin
         runState_nxt = ST_STOP; // [RULE3] [RULE6]
      end else if (!armed_r) begin
         runState_nxt = ST_STOP; // [RULE10]
      end else if (wireMode_r == `MODE_THREE_ONE) begin
         if (revEdge)
            runState_nxt = ST_REV; // [RULE2] [RULE4]
         else if (fwdEdge)
            runState_nxt = ST_FWD; // [RULE1] [RULE4]
         else if (runState_r == ST_STOP && runBtn && !protect_r)
            runState_nxt = ST_FWD; // [RULE9]
         else if (runState_r == ST_STOP && revBtn && !protect_r)
            runState_nxt = ST_REV; // [RULE9]
      end else if (wireMode_r == `MODE_THREE_TWO) begin
         // direction is the level switch while running
         if (runState_r != ST_STOP || fwdEdge || (runBtn && !protect_r))
            runState_nxt = revBtn ? ST_REV : ST_FWD; // [RULE5] [RULE6]
      end else begin
         runState_nxt = ST_STOP; // two-wire modes not handled here
      end
   end

   // run state, protection arming and outputs of the run logic
   // outputs follow the next state, so they trail the buttons by a clock
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         runState_r <= ST_STOP;
         accPrev_r  <= 4'h0;
         armed_r    <= 1'b0;
         runCmd     <= 1'b0;
         runReverse <= 1'b0;
      end else if (clkEn) begin
         accPrev_r <= accepted_r;
         // protection off arms at once; on, needs the run terminal low
         if (!protect_r)
            armed_r <= terminalsReady; // [RULE9]
         else if (terminalsReady && !runLevel)
            armed_r <= 1'b1; // [RULE10]
         case (runState_nxt)
            ST_STOP: runState_r <= ST_STOP;
            ST_FWD:  runState_r <= ST_FWD;
            ST_REV:  runState_r <= ST_REV;
            default: runState_r <= ST_STOP;
         endcase
         runCmd     <= (runState_nxt != ST_STOP);
         runReverse <= (runState_nxt == ST_REV);
      end
   end

   // with protection the level seen at arming is not an edge, so only a
   // fresh press after release can start; edges are gated by armed_r

   // virtual inputs from the selected parameter bit
   // an unknown source code reads as a zero word, never as stale data
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         virtualInputs <= 4'h0;
      end else if (clkEn) begin
         for (i = 0; i < 4; i = i + 1)
            virtualInputs[i] <= pickBit(srcWord(vinSrc_r[i]),
                                        vinDigits_r[4*i +: 4]); // [RULE12]
      end
   end

   // output selection: the code indexes the flag vector
   // codes above 31 wrap onto the low five bits; software must keep
   // them in range, the hardware does not check
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         outputPins <= 10'h000;
      end else if (clkEn) begin
         for (i = 0; i < NOUT; i = i + 1) begin
            // codes 0..27 [RULE15] [RULE16] [RULE17] [RULE18]
            // [RULE19] [RULE20] [RULE21]; code 0 and 24 stay off
            if (outFunc_r[i] == 6'h00 || outFunc_r[i] == 6'h18)
               outputPins[i] <= 1'b0;
            else if (outFunc_r[i] == 6'h02)
               outputPins[i] <= runCmd & ~runReverse;
            else if (outFunc_r[i] == 6'h08)
               outputPins[i] <= runCmd & runReverse;
            else
               outputPins[i] <= driveFlags[outFunc_r[i][4:0]];
         end
      end
   end

   // wishbone decode
   // the ten function words fill 0x20 to 0x47, so the mode, digit and
   // run-state words sit above them and never alias a function word
   wire        wbReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire [6:0]  wbAdr  = wb_adr_i[6:0];
   wire        fullWr = wbReq & wb_we_i & (wb_sel_i[1:0] == 2'h3);
   wire [6:0]  fnIdx  = (wbAdr - `OFS_OUT_FUNC_BASE) >> 2;
   wire        fnHit  = (wbAdr >= `OFS_OUT_FUNC_BASE) &&
                        (wbAdr <  `OFS_OUT_FUNC_BASE + 4 * NOUT);

   // register writes and single-wait acknowledge
   // a write needs both low byte lanes; a narrower write is acked but
   // dropped, so a half-updated setting never takes effect
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         wb_ack_o    <= 1'b0;
         wb_dat_o    <= 32'h00000000;
         filterMs_r  <= `RST_FILTER_MS;
         protect_r   <= 1'b0;
         readyMs_r   <= `RST_ON_READY_MS;
         vinSrc_r[0] <= `RST_VIN_SRC_A;
         vinSrc_r[1] <= `RST_VIN_SRC_A;
         vinSrc_r[2] <= `RST_VIN_SRC_B;
         vinSrc_r[3] <= `RST_VIN_SRC_C;
         vinDigits_r <= `RST_VIN_DIGITS;
         wireMode_r  <= `MODE_THREE_ONE;
         for (i = 0; i < NOUT; i = i + 1)
            outFunc_r[i] <= 6'h00;
         outFunc_r[2] <= `RST_RELAY1_FUNC; // [RULE22]
      end else if (clkEn) begin
         wb_ack_o <= wbReq;
         wb_dat_o <= 32'h00000000;
         if (wbReq && !wb_we_i) begin
            // read mux; unmapped reads as zero
            if (fnHit)
               wb_dat_o <= {26'h0, outFunc_r[fnIdx[3:0]]};
            else case (wbAdr)
               `OFS_FILTER_TIME:    wb_dat_o <= {16'h0, filterMs_r};
               `OFS_START_PROTECT:  wb_dat_o <= {31'h0, protect_r};
               `OFS_ON_READY_TIME:  wb_dat_o <= {16'h0, readyMs_r};
               `OFS_VIN_SRC_ONE:    wb_dat_o <= {16'h0, vinSrc_r[0]};
               `OFS_VIN_SRC_TWO:    wb_dat_o <= {16'h0, vinSrc_r[1]};
               `OFS_VIN_SRC_THREE:  wb_dat_o <= {16'h0, vinSrc_r[2]};
               `OFS_VIN_SRC_FOUR:   wb_dat_o <= {16'h0, vinSrc_r[3]};
               `OFS_OUT_PORT_STATE: // [RULE14]
                  wb_dat_o <= {22'h0, outputPins};
               `OFS_WIRE_MODE:      wb_dat_o <= {30'h0, wireMode_r};
               `OFS_VIN_DIGITS:     wb_dat_o <= {16'h0, vinDigits_r};
               `OFS_RUN_STATE:      wb_dat_o <= {29'h0, runState_r};
               default:             wb_dat_o <= 32'h00000000;
            endcase
         end
         if (fullWr) begin
            // range-clamped writes for the timing settings
            if (fnHit)
               outFunc_r[fnIdx[3:0]] <= wb_dat_i[5:0];
            else case (wbAdr)
               `OFS_FILTER_TIME:   filterMs_r <=
                  (wb_dat_i[15:0] > `MAX_FILTER_MS) ? `MAX_FILTER_MS
                                                    : wb_dat_i[15:0];
               `OFS_START_PROTECT: protect_r <= wb_dat_i[0];
               `OFS_ON_READY_TIME: readyMs_r <=
                  (wb_dat_i[15:0] > `MAX_ON_READY_MS) ? `MAX_ON_READY_MS
                                                      : wb_dat_i[15:0];
               `OFS_VIN_SRC_ONE:   vinSrc_r[0] <= wb_dat_i[15:0];
               `OFS_VIN_SRC_TWO:   vinSrc_r[1] <= wb_dat_i[15:0];
               `OFS_VIN_SRC_THREE: vinSrc_r[2] <= wb_dat_i[15:0];
               `OFS_VIN_SRC_FOUR:  vinSrc_r[3] <= wb_dat_i[15:0];
               `OFS_WIRE_MODE:     wireMode_r <= wb_dat_i[1:0];
               `OFS_VIN_DIGITS:    vinDigits_r <= wb_dat_i[15:0];
               default:            ;
            endcase
         end
      end
   end

endmodule

//--- hdl/drive_terminal_io_map.vh
/*
 * register map, reset values and timing figures of the drive terminal
 * logic. assumes a 25 MHz system clock and word-aligned wishbone offsets.
 */
`ifndef DRIVE_TERMINAL_IO_MAP_VH
`define DRIVE_TERMINAL_IO_MAP_VH

// byte offsets of the registers
`define OFS_FILTER_TIME     7'h00
`define OFS_START_PROTECT   7'h04
`define OFS_ON_READY_TIME   7'h08
`define OFS_VIN_SRC_ONE     7'h0C
`define OFS_VIN_SRC_TWO     7'h10
`define OFS_VIN_SRC_THREE   7'h14
`define OFS_VIN_SRC_FOUR    7'h18
`define OFS_OUT_PORT_STATE  7'h1C
`define OFS_OUT_FUNC_BASE   7'h20
// ten function words fill 0x20..0x47; the rest sit above them
`define OFS_WIRE_MODE       7'h48
`define OFS_VIN_DIGITS      7'h4C
`define OFS_RUN_STATE       7'h50
`define ADDR_W              7

// reset values and upper limits (filter and ready times in ms)
`define RST_FILTER_MS       16'h000A
`define MAX_FILTER_MS       16'h0064
`define RST_ON_READY_MS     16'h03E8
`define MAX_ON_READY_MS     16'h7530
`define RST_VIN_SRC_A       16'h0600
`define RST_VIN_SRC_B       16'h0700
`define RST_VIN_SRC_C       16'h4400
`define RST_VIN_DIGITS      16'h0003
`define RST_RELAY1_FUNC     6'h03

// wire modes
`define MODE_THREE_ONE      2'h2
`define MODE_THREE_TWO      2'h3

// time base
`define CLK_HZ              25000000
`define MS_PER_S            1000
`define CYC_PER_MS          (`CLK_HZ / `MS_PER_S)

`endif

//--- dv/drive_terminal_io_sva.sv
/* bus handshake and run output checker for drive_terminal_io.
   assumes it is bound to the design and sees only its ports. */
`timescale 1ns/1ps
module drive_terminal_io_sva (
   input wire        sys_clk,
   input wire        sys_rst,
   input wire        clkEn,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [31:0] wb_adr_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   input wire        runCmd,
   input wire        runReverse,
   input wire        terminalsReady,
   input wire [3:0]  virtualInputs,
   input wire [9:0]  outputPins
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // a request that the slave may take on this edge
   wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn;
   a_ack_answer: assert property (req |=> wb_ack_o)
      else $error("request not acknowledged");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_no_stray: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_unmapped_zero: assert property (req && !wb_we_i &&
      wb_adr_i[6:0] > 7'h50 |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_status_read: assert property (req && !wb_we_i &&
      wb_adr_i[6:0] == 7'h1C && $stable(outputPins)
      |=> wb_dat_o[9:0] == $past(outputPins))
      else $error("status word differs from pins");
   // own disable: the check is about the reset itself
   a_reset_clear: assert property (disable iff (1'b0) sys_rst |=>
      !runCmd && !terminalsReady && outputPins == 10'h000 &&
      virtualInputs == 4'h0 && !wb_ack_o)
      else $error("outputs not cleared by reset");
   a_run_ready: assert property ($rose(runCmd) |->
      $past(terminalsReady))
      else $error("run started before terminals ready");
   c_write: cover property (req && wb_we_i);
   c_run: cover property ($rose(runCmd));
   c_reverse: cover property ($rose(runReverse));
endmodule
bind drive_terminal_io drive_terminal_io_sva drive_terminal_io_sva_inst (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .runCmd(runCmd), .runReverse(runReverse),
   .terminalsReady(terminalsReady), .virtualInputs(virtualInputs),
   .outputPins(outputPins));

//--- dv/operator_panel.sv
/* operator panel model: stop-enable, run and direction contacts and
   the pulse input. assumes the bench sets the contact levels. */
`timescale 1ns/1ps
module operator_panel (
   input  wire       sys_clk,
   input  wire [3:0] contacts,
   output reg  [3:0] terminalIn = 4'h0
);
   // contacts reach the wire one clock after the bench moves them
   always @(posedge sys_clk) begin
      terminalIn <= contacts;
   end
endmodule

//--- dv/testbench.sv
/* self-checking bench for drive_terminal_io with an operator panel.
   assumes the register map header and a 25 MHz clock. */
`timescale 1ns/1ps
`include "drive_terminal_io_map.vh"
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin \
   mismatches++; $display("wrong value at %0t: %h vs %h", $time, g, e); \
   end end
module testbench;
   reg         sys_clk = 1'b0;
   reg         sys_rst = 1'b1;
   reg         cyc = 1'b0, stb = 1'b0, we = 1'b0;
   reg         clkEn = 1'b1, expBit;
   reg  [31:0] adr = 32'h0, datW = 32'h0, flags = 32'h0, seed = 32'hA;
   reg  [3:0]  sel = 4'h0, contacts = 4'h0;
   reg  [15:0] bankA = 16'h0, bankB = 16'h0, bankC = 16'h0, d;
   reg  [31:0] rd, r;
   wire [31:0] datR;
   wire        ack, runCmd, runReverse, terminalsReady;
   wire [3:0]  terminalIn, virtualInputs;
   wire [9:0]  outputPins;
   integer     mismatches = 0, samplesChecked = 0, i, outIdx;
   // free-running 25 MHz clock
   always #20 sys_clk = ~sys_clk;
   operator_panel operator_panel_inst (.sys_clk(sys_clk),
      .contacts(contacts), .terminalIn(terminalIn));
   drive_terminal_io drive_terminal_io_inst (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .clkEn(clkEn), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW),
      .wb_dat_o(datR), .wb_ack_o(ack), .terminalIn(terminalIn),
      .driveFlags(flags), .paramBankA(bankA), .paramBankB(bankB),
      .paramBankC(bankC), .runCmd(runCmd), .runReverse(runReverse),
      .terminalsReady(terminalsReady), .virtualInputs(virtualInputs),
      .outputPins(outputPins));
   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // pin level expected for a function code while running forward
   function logic expOut(input [5:0] c, input [31:0] f);
      case (c)
         6'h00, 6'h18: expOut = 1'b0;
         6'h02: expOut = 1'b1;
         6'h08: expOut = 1'b0;
         default: expOut = f[c[4:0]];
      endcase
   endfunction
   // virtual input levels expected from the reset source codes
   function logic [3:0] expVin(input [15:0] dg);
      expVin = {bankC[dg[15:12]], bankB[dg[11:8]], bankA[dg[7:4]],
                bankA[dg[3:0]]};
   endfunction
   // classic cycle, held until ack is seen at an edge
   task bus(input [6:0] a, input w, input [3:0] s, input [15:0] v);
      integer n;
      begin
         @(posedge sys_clk);
         cyc <= 1'b1; stb <= 1'b1; we <= w; sel <= s;
         adr <= {25'h0, a}; datW <= {16'h0, v};
         n = 0;
         @(posedge sys_clk);
         while (ack !== 1'b1 && n < 50) begin
            @(posedge sys_clk);
            n = n + 1;
         end
         if (n == 50) mismatches++;
         rd = datR;
         cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      end
   endtask
   task rdExp(input [6:0] a, input [31:0] e);
      begin
         bus(a, 1'b0, 4'hF, 16'h0);
         `CHK(rd, e)
      end
   endtask
   // move the contacts, let sync and run logic settle, compare
   task step(input [3:0] c, input eRun, input eRev);
      begin
         @(posedge sys_clk);
         contacts <= c;
         repeat (8) @(posedge sys_clk);
         `CHK(runCmd, eRun)
         if (eRun) `CHK(runReverse, eRev)
      end
   endtask
   task doReset;
      begin
         @(posedge sys_clk);
         sys_rst <= 1'b1;
         repeat (4) @(posedge sys_clk);
         sys_rst <= 1'b0;
      end
   endtask
   task quick; // zero filter and ready time for fast tests
      begin
         bus(`OFS_FILTER_TIME, 1'b1, 4'hF, 16'h0);
         bus(`OFS_ON_READY_TIME, 1'b1, 4'hF, 16'h0);
         repeat (10) @(posedge sys_clk);
      end
   endtask
   task testDone;
      begin
         if (mismatches == 0 && samplesChecked > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   // watchdog: the run needs about 26000 cycles, most in the filter wait
   initial begin
      repeat (60000) @(posedge sys_clk);
      mismatches++;
      testDone;
   end
   initial begin
      doReset;
      rdExp(`OFS_FILTER_TIME, 32'hA);
      rdExp(`OFS_START_PROTECT, 32'h0);
      rdExp(`OFS_ON_READY_TIME, 32'h3E8);
      rdExp(`OFS_VIN_SRC_ONE, 32'h600);
      rdExp(`OFS_VIN_SRC_TWO, 32'h600);
      rdExp(`OFS_VIN_SRC_THREE, 32'h700);
      rdExp(`OFS_VIN_SRC_FOUR, 32'h4400);
      rdExp(`OFS_VIN_DIGITS, 32'h3);
      rdExp(`OFS_WIRE_MODE, 32'h2);
      for (i = 0; i < 7; i++)
         rdExp(7'h20 + 4 * i, (i == 2) ? 32'h3 : 32'h0);
      bus(7'h7C, 1'b1, 4'hF, 16'hFFFF);
      rdExp(7'h7C, 32'h0);
      bus(7'h28, 1'b1, 4'hC, 16'h5); // partial sel is ignored
      rdExp(7'h28, 32'h3);
      bus(`OFS_FILTER_TIME, 1'b1, 4'hF, 16'hFFFF);
      rdExp(`OFS_FILTER_TIME, 32'h64);
      bus(`OFS_ON_READY_TIME, 1'b1, 4'hF, 16'hFFFF);
      rdExp(`OFS_ON_READY_TIME, 32'h7530);
      quick;
      `CHK(terminalsReady, 1'b1)
      // three-wire mode one
      step(4'h1, 1'b0, 1'b0);
      step(4'h3, 1'b1, 1'b0);
      step(4'h1, 1'b1, 1'b0);
      step(4'h5, 1'b1, 1'b1);
      rdExp(`OFS_RUN_STATE, 32'h4);
      step(4'h1, 1'b1, 1'b1);
      step(4'h3, 1'b1, 1'b0);
      rdExp(`OFS_RUN_STATE, 32'h2);
      step(4'h1, 1'b1, 1'b0);
      // every function code while running forward, random flags
      for (i = 0; i < 28; i++) begin
         outIdx = i % 7;
         flags <= xs();
         bus(7'h20 + 4 * outIdx, 1'b1, 4'hF, i);
         repeat (3) @(posedge sys_clk);
         expBit = expOut(i, flags);
         `CHK(outputPins[outIdx], expBit)
         bus(`OFS_OUT_PORT_STATE, 1'b0, 4'hF, 16'h0);
         `CHK(rd[outIdx], expBit)
      end
      step(4'h0, 1'b0, 1'b0);
      step(4'h2, 1'b0, 1'b0);
      step(4'h1, 1'b0, 1'b0);
      // a short enable glitch is filtered, a long open stops
      step(4'h3, 1'b1, 1'b0);
      step(4'h1, 1'b1, 1'b0);
      bus(`OFS_FILTER_TIME, 1'b1, 4'hF, 16'h1);
      contacts <= 4'h0;
      repeat (200) @(posedge sys_clk);
      contacts <= 4'h1;
      repeat (100) @(posedge sys_clk);
      `CHK(runCmd, 1'b1)
      contacts <= 4'h0;
      repeat (24900) @(posedge sys_clk);
      `CHK(runCmd, 1'b1)
      repeat (300) @(posedge sys_clk);
      `CHK(runCmd, 1'b0)
      bus(`OFS_FILTER_TIME, 1'b1, 4'hF, 16'h0);
      // virtual inputs pick random bits of random words
      for (i = 0; i < 6; i++) begin
         bankA <= xs();
         bankB <= xs();
         bankC <= xs();
         r = xs();
         d = r[15:0];
         bus(`OFS_VIN_DIGITS, 1'b1, 4'hF, d);
         repeat (4) @(posedge sys_clk);
         `CHK(virtualInputs, expVin(d))
      end
      // three-wire mode two
      bus(`OFS_WIRE_MODE, 1'b1, 4'hF, 16'h3);
      step(4'h1, 1'b0, 1'b0);
      step(4'h3, 1'b1, 1'b0);
      step(4'h1, 1'b1, 1'b0);
      step(4'h5, 1'b1, 1'b1);
      step(4'h4, 1'b0, 1'b0);
      step(4'h6, 1'b0, 1'b0);
      // run terminal held through reset, without then with protection
      // no protection: closing enable with run held starts at once
      step(4'h3, 1'b1, 1'b0);
      doReset;
      quick;
      `CHK(runCmd, 1'b1)
      doReset;
      bus(`OFS_START_PROTECT, 1'b1, 4'hF, 16'h1);
      quick;
      `CHK(runCmd, 1'b0)
      step(4'h1, 1'b0, 1'b0);
      step(4'h3, 1'b1, 1'b0);
      // a low clock enable freezes the run logic
      clkEn <= 1'b0;
      contacts <= 4'h0;
      repeat (8) @(posedge sys_clk);
      `CHK(runCmd, 1'b1)
      clkEn <= 1'b1;
      repeat (8) @(posedge sys_clk);
      `CHK(runCmd, 1'b0)
      testDone;
   end
endmodule
